/* hw/srf_pkg.sv */
// Constants shared by the sensor reset and fault sequencer
package srf_pkg;
    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_HZ = 50000000;
    localparam int STARTUP_US = 40;
    localparam int STARTUP_CYC = (CLK_HZ / 1000000) * STARTUP_US;
    localparam int CHECK_HZ = 24;
    // Half period of the excitation, rounded down
    localparam int CHECK_HALF_CYC = CLK_HZ / (2 * CHECK_HZ);
    localparam int CNT_W = 24;
    // Synchroniser reset: no external reset, no self-test request
    localparam logic [3:0] SYNC_IDLE = 4'h2;
    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        SRF_OFF = 4'h1,
        SRF_START = 4'h2,
        SRF_RUN = 4'h4,
        SRF_HOLD = 4'h8
    } srf_state_type;
    // Output line drive codes: middle, normal signal, check high, check low
    localparam logic [1:0] LINE_MID = 2'h0;
    localparam logic [1:0] LINE_SIG = 2'h1;
    localparam logic [1:0] LINE_HI = 2'h2;
    localparam logic [1:0] LINE_LO = 2'h3;
endpackage : srf_pkg

/* hw/srf_sequencer.sv */
// Startup, reset, self-test and fault sequencer of the accelerometer
`timescale 1ns/1ps
// What this block does
// - Hold supply_ok low below trip level; start sequence once level is reached.
// - Supply drop drives supply_ok low; full new startup after recovery.
// - Fault flag high from power-up until startup completes.
// - External reset is active low; an undriven pin reads as no reset.
// - During external reset both lines forced to mid-rail, fault flag high.
// - Self-test request is active high; undriven pin keeps it off.
// - While self-test is requested, drive a 24 Hz square-wave excitation.
// - Fault flag high while supply low, during reset, during overload.
// - Overload resets readout and restarts startup until overload clears.
// - Operational about 40 microseconds after the startup sequence begins.
module srf_sequencer #(
    parameter int STARTUP_CYCLES = srf_pkg::STARTUP_CYC,
    parameter int CHECK_HALF_CYCLES = srf_pkg::CHECK_HALF_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and monitors, all asynchronous
    input wire logic supply_good,
    input wire logic ext_reset_n,
    input wire logic check_mode_enable,
    input wire logic overload_detect,
    // Outputs
    output logic supply_ok_signal,
    output logic fault_flag,
    output logic [1:0] plus_signal_line,
    output logic [1:0] minus_signal_line,
    output logic check_excite,
    output logic readout_reset
);
    import srf_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic sup_s;
    logic rst_n_s;
    logic chk_s;
    logic ovl_s;

    // Undriven pins idle as pulled: reset high, self-test low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= SYNC_IDLE;
            sync_r <= SYNC_IDLE;
        end else begin
            meta_r <= {overload_detect, check_mode_enable, ext_reset_n, supply_good};
            sync_r <= meta_r;
        end
    end
    assign sup_s = sync_r[0];
    assign rst_n_s = sync_r[1];
    assign chk_s = sync_r[2];
    assign ovl_s = sync_r[3];

    // ************************************************************
    // Startup sequencer
    // ************************************************************
    srf_state_type state_r;
    logic [CNT_W-1:0] start_cnt_r;
    logic start_done;
    assign start_done = (start_cnt_r == CNT_W'(STARTUP_CYCLES - 1));

    // Any invalidating cause drops back; startup restarts from zero each time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= SRF_OFF;
            start_cnt_r <= '0;
        end else begin
            case (state_r)
                SRF_OFF: begin
                    start_cnt_r <= '0;
                    if (sup_s) begin
                        state_r <= SRF_START;
                    end
                end
                SRF_START: begin
                    if (!sup_s) begin
                        state_r <= SRF_OFF;
                    end else if (!rst_n_s || ovl_s) begin
                        state_r <= SRF_HOLD;
                    end else if (start_done) begin
                        state_r <= SRF_RUN;
                    end else begin
                        start_cnt_r <= start_cnt_r + CNT_W'(1);
                    end
                end
                SRF_RUN: begin
                    start_cnt_r <= '0;
                    if (!sup_s) begin
                        state_r <= SRF_OFF;
                    end else if (!rst_n_s || ovl_s) begin
                        state_r <= SRF_HOLD;
                    end
                end
                SRF_HOLD: begin
                    start_cnt_r <= '0;
                    if (!sup_s) begin
                        state_r <= SRF_OFF;
                    end else if (rst_n_s && !ovl_s) begin
                        state_r <= SRF_START;
                    end
                end
                default: begin
                    state_r <= SRF_OFF;
                    start_cnt_r <= '0;
                end
            endcase
        end
    end

    // ************************************************************
    // Self-test excitation
    // ************************************************************
    logic [CNT_W-1:0] half_cnt_r;
    logic phase_r;

    // Free divider only while requested; phase starts high on each request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half_cnt_r <= '0;
            phase_r <= 1'b0;
        end else if (!chk_s) begin
            half_cnt_r <= '0;
            phase_r <= 1'b1;
        end else if (half_cnt_r == CNT_W'(CHECK_HALF_CYCLES - 1)) begin
            half_cnt_r <= '0;
            phase_r <= ~phase_r;
        end else begin
            half_cnt_r <= half_cnt_r + CNT_W'(1);
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    logic run_nxt;
    assign run_nxt = (state_r == SRF_RUN);

    // Faults cover startup, reset, overload and low supply
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supply_ok_signal <= 1'b0;
            fault_flag <= 1'b1;
            readout_reset <= 1'b1;
            check_excite <= 1'b0;
            plus_signal_line <= LINE_MID;
            minus_signal_line <= LINE_MID;
        end else begin
            supply_ok_signal <= sup_s;
            fault_flag <= !(run_nxt && sup_s && rst_n_s && !ovl_s);
            readout_reset <= (state_r == SRF_HOLD) || (state_r == SRF_OFF);
            check_excite <= chk_s && phase_r;
            if (!rst_n_s || !run_nxt) begin
                plus_signal_line <= LINE_MID;
                minus_signal_line <= LINE_MID;
            end else if (chk_s) begin
                plus_signal_line <= phase_r ? LINE_HI : LINE_LO;
                minus_signal_line <= phase_r ? LINE_LO : LINE_HI;
            end else begin
                plus_signal_line <= LINE_SIG;
                minus_signal_line <= LINE_SIG;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_reset_mid: assert property (@(posedge clk) disable iff (rst)
        !rst_n_s |=> (plus_signal_line == LINE_MID) && (minus_signal_line == LINE_MID)
            && fault_flag)
        else $error("lines not at mid-rail during reset");
    chk_supply_fault: assert property (@(posedge clk) disable iff (rst)
        !sup_s |=> !supply_ok_signal && fault_flag)
        else $error("supply low without fault");
    chk_overload_fault: assert property (@(posedge clk) disable iff (rst)
        ovl_s |=> fault_flag && (state_r != SRF_RUN))
        else $error("overload did not stop operation");
    // A clean startup may only leave once the full count is reached
    chk_startup_len: assert property (@(posedge clk) disable iff (rst)
        (state_r == SRF_START) && !start_done && sup_s && rst_n_s && !ovl_s
            |=> state_r == SRF_START)
        else $error("startup ended too early");
    chk_fault_clear: assert property (@(posedge clk) disable iff (rst)
        $fell(fault_flag) |-> $past(state_r) == SRF_RUN)
        else $error("fault cleared before startup done");
    chk_run_entry: assert property (@(posedge clk) disable iff (rst)
        (state_r == SRF_START) && start_done && sup_s && rst_n_s && !ovl_s
            |=> state_r == SRF_RUN)
        else $error("startup did not complete");
    chk_check_toggle: assert property (@(posedge clk) disable iff (rst)
        chk_s && $past(chk_s) && (half_cnt_r == CNT_W'(0)) && $past(half_cnt_r) != CNT_W'(0)
            |-> phase_r != $past(phase_r))
        else $error("excitation phase did not toggle");
    chk_check_idle: assert property (@(posedge clk) disable iff (rst)
        !chk_s |=> !check_excite)
        else $error("excitation without request");
    chk_supply_loss: assert property (@(posedge clk) disable iff (rst)
        !sup_s |=> state_r == SRF_OFF)
        else $error("supply loss did not restart");
    // Output state follows the sequencer state one clock later
    chk_start_fault: assert property (@(posedge clk) disable iff (rst)
        state_r != SRF_RUN |=> fault_flag)
        else $error("fault low before startup done");
    chk_hold_readout: assert property (@(posedge clk) disable iff (rst)
        state_r == SRF_HOLD |=> readout_reset)
        else $error("readout not held during overload");
    chk_run_lines: assert property (@(posedge clk) disable iff (rst)
        (state_r == SRF_RUN) && rst_n_s && !chk_s
            |=> (plus_signal_line == LINE_SIG) && (minus_signal_line == LINE_SIG))
        else $error("lines not normal in operation");
    chk_check_lines: assert property (@(posedge clk) disable iff (rst)
        (state_r == SRF_RUN) && rst_n_s && chk_s
            |=> plus_signal_line[1] && minus_signal_line[1]
                && (plus_signal_line != minus_signal_line))
        else $error("excitation missing on lines");
endmodule : srf_sequencer

/* test/srf_host.sv */
// Host model driving the reset and self-test pins
`timescale 1ns/1ps
module srf_host (
    // Requests from the bench
    input wire logic req_reset,
    input wire logic req_check,
    // Pins toward the sensor
    output logic ext_reset_n,
    output logic check_mode_enable
);
    // Pull-up: a released pin reads as no reset
    assign ext_reset_n = req_reset ? 1'b0 : 1'b1;
    // Pull-down: self-test stays off unless asked for
    assign check_mode_enable = req_check ? 1'b1 : 1'b0;
endmodule : srf_host

/* test/tb.sv */
// Self-checking testbench of the sensor reset and fault sequencer
`timescale 1ns/1ps
module tb;
    import srf_pkg::*;
    // ************************************************************
    // Short counts keep the run brief
    // ************************************************************
    localparam int SC = 16;
    localparam int HC = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic supply_good = 1'b0;
    logic overload_detect = 1'b0;
    logic req_reset = 1'b0;
    logic req_check = 1'b0;
    logic ext_reset_n, check_mode_enable, supply_ok_signal, fault_flag;
    logic check_excite, readout_reset;
    logic [1:0] plus_signal_line, minus_signal_line;
    int error_cnt = 0;
    int compares = 0;
    int n;
    // Clock at 50 MHz
    always #10 clk = ~clk;
    srf_host host (.req_reset(req_reset), .req_check(req_check),
        .ext_reset_n(ext_reset_n), .check_mode_enable(check_mode_enable));
    srf_sequencer #(.STARTUP_CYCLES(SC), .CHECK_HALF_CYCLES(HC)) dut (.clk(clk), .rst(rst),
        .supply_good(supply_good), .ext_reset_n(ext_reset_n),
        .check_mode_enable(check_mode_enable), .overload_detect(overload_detect),
        .supply_ok_signal(supply_ok_signal), .fault_flag(fault_flag),
        .plus_signal_line(plus_signal_line), .minus_signal_line(minus_signal_line),
        .check_excite(check_excite), .readout_reset(readout_reset));
    // Inputs move 1 ns after the edge so sampling never races
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit
    task automatic cmp_code(input string what, input logic [1:0] exp, input logic [1:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_code
    task automatic cmp_cnt(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : cmp_cnt
    // Bounded waits: fault release, and one level of the plus line
    task automatic wait_clear(output int c);
        c = 0;
        while (fault_flag !== 1'b0 && c < 300) begin
            step(1);
            c++;
        end
    endtask : wait_clear
    task automatic half(output int c);
        logic [1:0] p;
        p = plus_signal_line;
        c = 0;
        while (plus_signal_line === p && c < 100) begin
            step(1);
            c++;
        end
    endtask : half
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // Watchdog well beyond the expected run of about 210 cycles
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
    initial begin
        step(6);
        rst = 1'b0;
        step(8);
        cmp_bit("supply_ok low", 1'b0, supply_ok_signal);
        cmp_bit("fault at power-up", 1'b1, fault_flag);
        supply_good = 1'b1;
        step(4);
        cmp_bit("supply_ok high", 1'b1, supply_ok_signal);
        cmp_bit("fault in startup", 1'b1, fault_flag);
        wait_clear(n);
        cmp_cnt("startup length", SC - 4, SC + 8, n + 4);
        step(2);
        cmp_code("plus normal", LINE_SIG, plus_signal_line);
        cmp_code("minus normal", LINE_SIG, minus_signal_line);
        cmp_bit("readout released", 1'b0, readout_reset);
        req_reset = 1'b1;
        step(4);
        cmp_bit("fault in reset", 1'b1, fault_flag);
        cmp_code("plus mid", LINE_MID, plus_signal_line);
        cmp_code("minus mid", LINE_MID, minus_signal_line);
        req_reset = 1'b0;
        wait_clear(n);
        cmp_cnt("restart after reset", SC, SC + 8, n);
        // Self-test only with the sensor at rest: overload stays low here
        req_check = 1'b1;
        step(4);
        cmp_bit("plus check code", 1'b1, plus_signal_line[1]);
        cmp_code("lines opposite", 2'h1, plus_signal_line ^ minus_signal_line);
        cmp_bit("excite high", 1'b1, check_excite);
        half(n);
        cmp_bit("excite low half", 1'b0, check_excite);
        half(n);
        cmp_cnt("first half", HC, HC, n);
        half(n);
        cmp_cnt("second half", HC, HC, n);
        req_check = 1'b0;
        step(4);
        cmp_code("plus after check", LINE_SIG, plus_signal_line);
        cmp_bit("excite off", 1'b0, check_excite);
        overload_detect = 1'b1;
        step(40);
        cmp_bit("fault in overload", 1'b1, fault_flag);
        cmp_bit("readout held", 1'b1, readout_reset);
        overload_detect = 1'b0;
        wait_clear(n);
        cmp_cnt("restart after overload", SC, SC + 8, n);
        supply_good = 1'b0;
        step(4);
        cmp_bit("supply_ok drop", 1'b0, supply_ok_signal);
        cmp_bit("fault on drop", 1'b1, fault_flag);
        supply_good = 1'b1;
        wait_clear(n);
        cmp_cnt("restart after drop", SC, SC + 8, n);
        // Reset in mid-startup must throw away the partial count
        req_reset = 1'b1;
        step(4);
        req_reset = 1'b0;
        step(8);
        req_reset = 1'b1;
        step(4);
        cmp_bit("fault in startup reset", 1'b1, fault_flag);
        cmp_bit("readout held in reset", 1'b1, readout_reset);
        req_reset = 1'b0;
        wait_clear(n);
        cmp_cnt("restart from zero", SC, SC + 8, n);
        stop_test();
    end
endmodule : tb
